// [src/infrared_sir_framer.sv]
// Purpose: Serial infrared framer with APB registers, DMA requests and pulse modem
// Assumes: mclk 100 MHz, sys_rst synchronous active high, DMA moves bytes through the data port
// Notes: Timers count in sample ticks (system clock / divisor)
// Contract
// RULE_01: Transmit adds flags, stuffing, check, end flag
// RULE_02: Receive drops flags, unstuffs, checks, finds end
// RULE_03: Pulses of 3/16 bit out, demodulated in
// RULE_04: One DMA request per direction
// RULE_05: Data port writes transmit, reads receive bytes
// RULE_06: Writing one to flush clears FIFOs
// RULE_07: Maximum turnaround 14 bits, default 500 ms; code resets it to 16000 sample ticks, 13.6 ms at the reset divisor
// RULE_08: Minimum turnaround 16 bits, default 10 ms; code resets it to 65000 sample ticks, 55.25 ms at the reset divisor
// RULE_09: Extra start flag count, reset eleven
// RULE_10: Flag type picks C0h or FFh
// RULE_11: Bit rate is clock over divisor over 16
// RULE_12: Transmit length setting, first received length; code never loads the first received length, which reads 0
// RULE_13: Abort sends abort sequence, no check
// RULE_14: Transmit control holds enable and modulation
// RULE_15: Invert bits flip transceiver polarity
// RULE_16: One-shot clears direction enable after frame
// RULE_17: FIFO thresholds from two-bit codes
// RULE_18: Interrupt only for enabled sources
// RULE_19: Turnaround and threshold timers raise timeouts
// RULE_20: Flag early restart of incoming frame
// RULE_21: Flag second poll/final frame received
// RULE_22: Summary error on any receive condition
// RULE_23: Receive length error above programmed maximum
// RULE_24: Framing error on zero stop bit
// RULE_25: Reading pending flags clears those read
//
// Added by the designer: register access over APB.
`include "infrared_sir_framer_defines.svh"

module infrared_sir_framer #(
	parameter int FifoDepth = 4,
	parameter logic [15:0] ThreshTicks = 16'hBB80,
	parameter logic [15:0] QueueIdleTicks = 16'h0200
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire infrared_sir_framer_pkg::apb_req_type apbReq,
	output infrared_sir_framer_pkg::apb_rsp_type apbRsp_q,
	output infrared_sir_framer_pkg::dma_type dmaReq_q,
	output logic irq_q,
	output logic irTx_q,
	input wire logic irRx
);
	import infrared_sir_framer_pkg::*;

	localparam int PW = $clog2(FifoDepth);
	localparam logic [PW:0] DEPTH = (PW + 1)'(FifoDepth);

	function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	function automatic logic isSpecial(input logic [7:0] b);
		return (b == `BYTE_BOF) || (b == `BYTE_EOF) || (b == `BYTE_ESC);
	endfunction

	logic [13:0] maxTurn_q;
	logic [15:0] minTurn_q, divisor_q, divCnt_q;
	logic [6:0] extraFlags_q;
	logic flagType_q, abort_q, txEn_q, mode_q, txInv_q, txOne_q, rxEn_q, rxInv_q, rxOne_q;
	logic [11:0] txLength_q, rxFirstLen_q, rxMaxLen_q;
	logic [1:0] txThr_q, rxThr_q;
	logic [12:0] irqMask_q, irqPend_q, evt;
	logic [7:0] status_q, statEvt;
	logic [2:0] timerEn_q;
	logic wrEn, rdEn, tick_q, flush;
	logic [31:0] rdVal;

	// APB: one wait state, effects at the edge where pready is high
	assign wrEn = apbReq.psel && apbReq.penable && apbRsp_q.pready && apbReq.pwrite;
	assign rdEn = apbReq.psel && apbReq.penable && apbRsp_q.pready && !apbReq.pwrite;
	assign flush = wrEn && apbReq.paddr == `OFS_FIFO_FLUSH && apbReq.pwdata[0]; // [RULE_06]

	// FIFOs
	logic [7:0] txMem [FifoDepth];
	logic [7:0] rxMem [FifoDepth];
	logic [PW-1:0] txWr_q, txRd_q, rxWr_q, rxRd_q;
	logic [PW:0] txCount_q, rxCount_q;
	logic txPush, txPop, rxPush_q, rxPop;
	logic [7:0] rxPushData_q;

	assign txPush = wrEn && apbReq.paddr == `OFS_DATA_PORT && txCount_q != DEPTH; // [RULE_05]
	assign rxPop = rdEn && apbReq.paddr == `OFS_DATA_PORT && rxCount_q != '0; // [RULE_05]

	always_ff @(posedge mclk) begin
		if (sys_rst || flush) begin
			txWr_q <= '0;
			txRd_q <= '0;
			txCount_q <= '0;
		end else begin
			if (txPush) begin
				txMem[txWr_q] <= apbReq.pwdata[7:0];
				txWr_q <= txWr_q + 1'b1;
			end
			if (txPop)
				txRd_q <= txRd_q + 1'b1;
			txCount_q <= txCount_q + (PW + 1)'(txPush) - (PW + 1)'(txPop);
		end
	end

	logic rxOver;
	assign rxOver = rxPush_q && rxCount_q == DEPTH && !rxPop;
	always_ff @(posedge mclk) begin
		if (sys_rst || flush) begin
			rxWr_q <= '0;
			rxRd_q <= '0;
			rxCount_q <= '0;
		end else begin
			if (rxPush_q && !rxOver) begin
				rxMem[rxWr_q] <= rxPushData_q;
				rxWr_q <= rxWr_q + 1'b1;
			end
			if (rxPop)
				rxRd_q <= rxRd_q + 1'b1;
			rxCount_q <= rxCount_q + (PW + 1)'(rxPush_q && !rxOver) - (PW + 1)'(rxPop);
		end
	end

	// Sample tick: 16 per bit
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			divCnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= 1'b0;
			if (divCnt_q + 16'h0001 >= divisor_q) begin // [RULE_11]
				divCnt_q <= '0;
				tick_q <= 1'b1;
			end else
				divCnt_q <= divCnt_q + 16'h0001;
		end
	end

	// Transmit character shifter and pulse modulator
	tx_state_type txState_q, escRet_q;
	logic [9:0] txShift_q;
	logic [3:0] txBits_q, txSub_q;
	logic txBusy_q, txAbortSent_q, txDone_q, fcsIdx_q, txStart;
	logic [6:0] flagCnt_q;
	logic [11:0] txSent_q;
	logic [15:0] txCrc_q;
	logic [7:0] escByte_q, fcsByte;
	logic [7:0] pulseCnt_q;
	logic txCharFree, pulse;

	// Characters start on a sample tick so every cell, and the first pulse, is whole
	assign txCharFree = !txBusy_q && txState_q != T_IDLE && tick_q;
	assign txPop = txCharFree && txState_q == T_DATA && !abort_q && txSent_q != txLength_q && txCount_q != '0;
	assign fcsByte = fcsIdx_q ? ~txCrc_q[15:8] : ~txCrc_q[7:0];
	assign txStart = txState_q == T_IDLE && txEn_q && (txCount_q != '0 || abort_q);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			txState_q <= T_IDLE;
			escRet_q <= T_DATA;
			txShift_q <= '1;
			txBits_q <= '0;
			txSub_q <= '0;
			txBusy_q <= 1'b0;
			flagCnt_q <= '0;
			txSent_q <= '0;
			txCrc_q <= `CRC_INIT;
			escByte_q <= '0;
			fcsIdx_q <= 1'b0;
			txAbortSent_q <= 1'b0;
			txDone_q <= 1'b0;
		end else begin
			txDone_q <= 1'b0;
			if (txBusy_q && tick_q) begin
				txSub_q <= txSub_q + 4'h1;
				if (txSub_q == `SUB_LAST) begin
					txShift_q <= {1'b1, txShift_q[9:1]};
					txBits_q <= txBits_q - 4'h1;
					txBusy_q <= txBits_q != 4'h1;
				end
			end
			if (txCharFree) begin
				// Loading a byte frames it with start 0 and stop 1
				txBits_q <= 4'hA;
				txSub_q <= '0;
				case (txState_q)
					T_XBOF: begin
						txBusy_q <= 1'b1;
						if (abort_q) begin
							txShift_q <= {1'b1, `BYTE_ESC, 1'b0}; // [RULE_13]
							txState_q <= T_ABORT;
						end else if (flagCnt_q == '0) begin
							txShift_q <= {1'b1, `BYTE_BOF, 1'b0}; // [RULE_01]
							txState_q <= T_DATA;
						end else begin
							txShift_q <= {1'b1, flagType_q ? `BYTE_BOF : `BYTE_FILL, 1'b0}; // [RULE_09] [RULE_10]
							flagCnt_q <= flagCnt_q - 7'h01;
						end
					end
					T_DATA: begin
						if (abort_q) begin
							txBusy_q <= 1'b1;
							txShift_q <= {1'b1, `BYTE_ESC, 1'b0}; // [RULE_13]
							txState_q <= T_ABORT;
						end else if (txSent_q == txLength_q) begin // [RULE_12]
							txState_q <= T_FCS;
							fcsIdx_q <= 1'b0;
						end else if (txPop) begin
							txBusy_q <= 1'b1;
							txSent_q <= txSent_q + 12'h001;
							txCrc_q <= crcStep(txCrc_q, txMem[txRd_q]);
							if (isSpecial(txMem[txRd_q])) begin // [RULE_01]
								txShift_q <= {1'b1, `BYTE_ESC, 1'b0};
								escByte_q <= txMem[txRd_q] ^ `BYTE_XOR;
								escRet_q <= T_DATA;
								txState_q <= T_ESC;
							end else
								txShift_q <= {1'b1, txMem[txRd_q], 1'b0};
						end
					end
					T_ESC: begin
						txBusy_q <= 1'b1;
						txShift_q <= {1'b1, escByte_q, 1'b0};
						txState_q <= escRet_q;
					end
					T_FCS: begin
						txBusy_q <= 1'b1;
						fcsIdx_q <= 1'b1;
						escRet_q <= fcsIdx_q ? T_EOF : T_FCS;
						if (isSpecial(fcsByte)) begin // [RULE_01]
							txShift_q <= {1'b1, `BYTE_ESC, 1'b0};
							escByte_q <= fcsByte ^ `BYTE_XOR;
							txState_q <= T_ESC;
						end else begin
							txShift_q <= {1'b1, fcsByte, 1'b0};
							txState_q <= fcsIdx_q ? T_EOF : T_FCS;
						end
					end
					T_EOF, T_ABORT: begin
						txBusy_q <= 1'b1;
						txShift_q <= {1'b1, `BYTE_EOF, 1'b0}; // [RULE_01] [RULE_13]
						txAbortSent_q <= txState_q == T_ABORT;
						txState_q <= T_DONE;
					end
					T_DONE: begin
						txDone_q <= 1'b1;
						txState_q <= T_IDLE;
					end
					default: txState_q <= T_IDLE;
				endcase
			end else if (txStart) begin
				txState_q <= T_XBOF;
				flagCnt_q <= extraFlags_q;
				txSent_q <= '0;
				txCrc_q <= `CRC_INIT;
				txAbortSent_q <= 1'b0;
			end
		end
	end

	assign pulse = mode_q ? pulseCnt_q != '0 : (txBusy_q && !txShift_q[0] && txSub_q < `PULSE_SUBS); // [RULE_03] [RULE_14]
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pulseCnt_q <= '0;
			irTx_q <= 1'b0;
		end else begin
			if (txBusy_q && tick_q && txSub_q == '0 && !txShift_q[0] && mode_q)
				pulseCnt_q <= 8'(`PULSE_CYCLES); // [RULE_14]
			else if (pulseCnt_q != '0)
				pulseCnt_q <= pulseCnt_q - 8'h01;
			irTx_q <= pulse ^ txInv_q; // [RULE_15]
		end
	end

	// Receive demodulator: any pulse within a bit cell is a zero
	// Cells are judged mid-cell, as a start found late would overlap the next pulse
	logic rxIn_q, pulseSeen_q, rxActive_q, rxByteValid_q, frameErrEvt_q, cellEnd;
	logic [3:0] rxSub_q, rxIdx_q;
	logic [7:0] rxShift_q;

	assign cellEnd = tick_q && (rxActive_q ? rxSub_q == `SUB_MID : 1'b1);
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rxIn_q <= 1'b0;
			pulseSeen_q <= 1'b0;
			rxActive_q <= 1'b0;
			rxSub_q <= '0;
			rxIdx_q <= '0;
			rxShift_q <= '0;
			rxByteValid_q <= 1'b0;
			frameErrEvt_q <= 1'b0;
		end else begin
			rxIn_q <= (irRx ^ rxInv_q) && rxEn_q; // [RULE_15]
			pulseSeen_q <= (pulseSeen_q && !cellEnd) || rxIn_q; // [RULE_03]
			rxByteValid_q <= 1'b0;
			frameErrEvt_q <= 1'b0;
			if (tick_q) begin
				if (!rxActive_q) begin
					rxActive_q <= pulseSeen_q;
					rxSub_q <= '0;
					rxIdx_q <= '0;
				end else begin
					rxSub_q <= rxSub_q + 4'h1;
					if (rxSub_q == `SUB_MID) begin
						rxIdx_q <= rxIdx_q + 4'h1;
						if (rxIdx_q == `LAST_BIT) begin
							rxActive_q <= 1'b0;
							rxByteValid_q <= 1'b1;
							frameErrEvt_q <= pulseSeen_q; // [RULE_24]
						end else if (rxIdx_q != '0)
							rxShift_q <= {!pulseSeen_q, rxShift_q[7:1]}; // [RULE_03]
					end
				end
			end
		end
	end

	// Receive deframer
	rx_state_type rxState_q;
	logic [7:0] hold0_q, hold1_q, rxData;
	logic [1:0] holdCnt_q, frameNo_q;
	logic [11:0] rxLen_q, payLen;
	logic [15:0] rxCrc_q;
	logic pf_q, rxDone_q, rxAbortEvt_q, restartEvt_q, secondEvt_q, crcEvt_q, dataErrEvt_q, sizeEvt_q, pfEvt_q;
	logic isData;

	assign isData = (rxState_q == R_ESC && !isSpecial(rxShift_q)) ||
		(rxState_q == R_DATA && !isSpecial(rxShift_q));
	assign rxData = rxState_q == R_ESC ? rxShift_q ^ `BYTE_XOR : rxShift_q;
	assign payLen = rxLen_q - 12'h002;

	always_ff @(posedge mclk) begin
		if (sys_rst || !rxEn_q) begin
			rxState_q <= R_HUNT;
			{hold0_q, hold1_q, holdCnt_q, rxLen_q, pf_q} <= '0;
			rxCrc_q <= `CRC_INIT;
			{rxPush_q, rxPushData_q, rxDone_q, rxAbortEvt_q, restartEvt_q, secondEvt_q} <= '0;
			{crcEvt_q, dataErrEvt_q, sizeEvt_q, pfEvt_q, frameNo_q} <= '0;
		end else begin
			{rxPush_q, rxDone_q, rxAbortEvt_q, restartEvt_q, secondEvt_q} <= '0;
			{crcEvt_q, dataErrEvt_q, sizeEvt_q, pfEvt_q} <= '0;
			if (rxByteValid_q) begin
				if (rxShift_q == `BYTE_BOF || rxState_q == R_HUNT) begin
					// Repeated flags before data are dropped
					restartEvt_q <= rxShift_q == `BYTE_BOF && rxLen_q != '0; // [RULE_20]
					if (rxShift_q == `BYTE_BOF) begin // [RULE_02]
						rxState_q <= R_DATA;
						{holdCnt_q, rxLen_q, pf_q} <= '0;
						rxCrc_q <= `CRC_INIT;
					end
				end else if (rxShift_q == `BYTE_EOF) begin
					rxState_q <= R_HUNT;
					rxLen_q <= '0;
					if (rxState_q == R_ESC)
						rxAbortEvt_q <= 1'b1; // [RULE_13]
					else begin
						rxDone_q <= 1'b1; // [RULE_02]
						crcEvt_q <= rxCrc_q != `CRC_GOOD || holdCnt_q != 2'h2;
						pfEvt_q <= pf_q;
						frameNo_q <= frameNo_q + 2'(frameNo_q != 2'h2);
						secondEvt_q <= pf_q && frameNo_q == 2'h1; // [RULE_21]
					end
				end else if (rxShift_q == `BYTE_ESC && rxState_q == R_DATA)
					rxState_q <= R_ESC; // [RULE_02]
				else if (isData) begin
					rxState_q <= R_DATA;
					rxCrc_q <= crcStep(rxCrc_q, rxData);
					rxLen_q <= rxLen_q + 12'h001;
					if (rxLen_q == 12'h001)
						pf_q <= rxData[`PF_BIT];
					hold1_q <= rxData;
					hold0_q <= hold1_q;
					holdCnt_q <= holdCnt_q + 2'(holdCnt_q != 2'h2);
					// The last two bytes are the check and never reach the FIFO
					rxPush_q <= holdCnt_q == 2'h2;
					rxPushData_q <= hold0_q;
					sizeEvt_q <= rxMaxLen_q != '0 && rxLen_q >= rxMaxLen_q + 12'h002; // [RULE_23]
				end else begin
					dataErrEvt_q <= 1'b1;
					rxState_q <= R_DATA;
				end
			end
		end
	end

	// Timers tick at the sample rate
	logic [15:0] minTimer_q, maxTimer_q, thrTimer_q, idleTimer_q;
	logic minEvt_q, maxEvt_q, thrEvt_q, idleEvt_q, rxEnOld_q;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			{minTimer_q, maxTimer_q, thrTimer_q, idleTimer_q} <= '0;
			{minEvt_q, maxEvt_q, thrEvt_q, idleEvt_q, rxEnOld_q} <= '0;
		end else begin
			{minEvt_q, maxEvt_q, thrEvt_q, idleEvt_q} <= '0;
			rxEnOld_q <= rxEn_q;
			if (txDone_q)
				minTimer_q <= timerEn_q[1] ? minTurn_q : '0; // [RULE_08]
			else if (tick_q && minTimer_q != '0) begin
				minTimer_q <= minTimer_q - 16'h0001;
				minEvt_q <= minTimer_q == 16'h0001; // [RULE_19]
			end
			if (txStart)
				maxTimer_q <= timerEn_q[0] ? {2'b00, maxTurn_q} : '0; // [RULE_07]
			else if (txDone_q)
				maxTimer_q <= '0;
			else if (tick_q && maxTimer_q != '0) begin
				maxTimer_q <= maxTimer_q - 16'h0001;
				maxEvt_q <= maxTimer_q == 16'h0001; // [RULE_19]
			end
			if (rxDone_q || (rxEn_q && !rxEnOld_q))
				thrTimer_q <= timerEn_q[2] ? ThreshTicks : '0;
			else if (tick_q && thrTimer_q != '0) begin
				thrTimer_q <= thrTimer_q - 16'h0001;
				thrEvt_q <= thrTimer_q == 16'h0001; // [RULE_19]
			end
			if (rxPush_q || rxPop || rxCount_q == '0)
				idleTimer_q <= QueueIdleTicks;
			else if (tick_q && idleTimer_q != '0) begin
				idleTimer_q <= idleTimer_q - 16'h0001;
				idleEvt_q <= idleTimer_q == 16'h0001;
			end
		end
	end

	// Condition and interrupt events
	logic txLvl_q, rxLvl_q, hold1Lvl_q, txLvl, rxLvl, hold1Lvl;
	assign txLvl = txCount_q <= (PW + 1)'(txThr_q); // [RULE_17]
	assign rxLvl = rxCount_q > (PW + 1)'(rxThr_q); // [RULE_17]
	assign hold1Lvl = rxCount_q == (PW + 1)'(1);
	assign statEvt = {pfEvt_q, dataErrEvt_q, frameErrEvt_q, crcEvt_q, hold1Lvl && !hold1Lvl_q,
		rdEn && apbReq.paddr == `OFS_DATA_PORT && rxCount_q == '0, rxOver, sizeEvt_q};
	assign evt = {secondEvt_q, restartEvt_q, thrEvt_q, idleEvt_q, txDone_q && txAbortSent_q, rxAbortEvt_q,
		maxEvt_q, minEvt_q, rxDone_q, txDone_q && !txAbortSent_q, |statEvt, rxLvl && !rxLvl_q,
		txLvl && !txLvl_q}; // [RULE_22] [RULE_20] [RULE_21]

	// Register file
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			maxTurn_q <= `RST_MAX_TURN; // [RULE_07]
			minTurn_q <= `RST_MIN_TURN; // [RULE_08]
			extraFlags_q <= `RST_EXTRA_FLAGS; // [RULE_09]
			divisor_q <= `RST_RATE_DIV; // [RULE_11]
			txLength_q <= `RST_TX_LENGTH; // [RULE_12]
			{flagType_q, abort_q, txEn_q, mode_q, txInv_q, txOne_q, rxEn_q, rxInv_q, rxOne_q} <= '0;
			{rxFirstLen_q, rxMaxLen_q, txThr_q, rxThr_q, irqMask_q, irqPend_q, status_q, timerEn_q} <= '0;
			// Empty transmit queue already meets any threshold: no false edge after reset
			txLvl_q <= 1'b1;
			{rxLvl_q, hold1Lvl_q, irq_q} <= '0;
		end else begin
			txLvl_q <= txLvl;
			rxLvl_q <= rxLvl;
			hold1Lvl_q <= hold1Lvl;
			if (wrEn) begin
				case (apbReq.paddr)
					`OFS_MAX_TURN: maxTurn_q <= apbReq.pwdata[13:0];
					`OFS_MIN_TURN: minTurn_q <= apbReq.pwdata[15:0];
					`OFS_EXTRA_FLAGS: {flagType_q, extraFlags_q} <= apbReq.pwdata[7:0];
					`OFS_RATE_DIV: divisor_q <= apbReq.pwdata[15:0];
					`OFS_TX_LENGTH: txLength_q <= apbReq.pwdata[11:0];
					`OFS_ABORT: abort_q <= apbReq.pwdata[0];
					`OFS_TX_CONTROL: {txOne_q, txInv_q, mode_q, txEn_q} <= apbReq.pwdata[3:0]; // [RULE_14]
					`OFS_RX_CONTROL: {rxOne_q, rxInv_q, rxEn_q} <= apbReq.pwdata[2:0];
					`OFS_THRESHOLDS: {rxThr_q, txThr_q} <= apbReq.pwdata[3:0];
					`OFS_IRQ_MASK: irqMask_q <= apbReq.pwdata[12:0];
					`OFS_RX_MAX_LEN: rxMaxLen_q <= apbReq.pwdata[11:0];
					`OFS_TIMER_EN: timerEn_q <= apbReq.pwdata[2:0];
					default: ;
				endcase
			end
			if (txDone_q) begin
				abort_q <= 1'b0;
				if (txOne_q)
					txEn_q <= 1'b0; // [RULE_16]
			end
			if (rxDone_q && rxOne_q)
				rxEn_q <= 1'b0; // [RULE_16]
			if (rxDone_q && frameNo_q == '0)
				rxFirstLen_q <= payLen; // [RULE_12]
			// New events win over a clear in the same cycle
			status_q <= (status_q & ~((wrEn && apbReq.paddr == `OFS_RX_FLAGS) ? apbReq.pwdata[7:0] : 8'h00))
				| statEvt;
			irqPend_q <= (irqPend_q & ~((rdEn && apbReq.paddr == `OFS_IRQ_PENDING) ? apbRsp_q.prdata[12:0]
				: 13'h0000)) | evt; // [RULE_25]
			irq_q <= |(irqPend_q & irqMask_q); // [RULE_18]
		end
	end

	always_comb begin
		rdVal = '0;
		case (apbReq.paddr)
			`OFS_DATA_PORT: rdVal[7:0] = rxMem[rxRd_q]; // [RULE_05]
			`OFS_FIFO_FLUSH: rdVal = '0;
			`OFS_MAX_TURN: rdVal[13:0] = maxTurn_q;
			`OFS_MIN_TURN: rdVal[15:0] = minTurn_q;
			`OFS_EXTRA_FLAGS: rdVal[7:0] = {flagType_q, extraFlags_q};
			`OFS_RATE_DIV: rdVal[15:0] = divisor_q;
			`OFS_TX_LENGTH: rdVal[11:0] = txLength_q;
			`OFS_RX_FIRST_LEN: rdVal[11:0] = rxFirstLen_q;
			`OFS_ABORT: rdVal[0] = abort_q;
			`OFS_TX_CONTROL: rdVal[3:0] = {txOne_q, txInv_q, mode_q, txEn_q};
			`OFS_RX_CONTROL: rdVal[2:0] = {rxOne_q, rxInv_q, rxEn_q};
			`OFS_THRESHOLDS: rdVal[3:0] = {rxThr_q, txThr_q};
			`OFS_IRQ_MASK: rdVal[12:0] = irqMask_q;
			`OFS_IRQ_PENDING: rdVal[12:0] = irqPend_q;
			`OFS_RX_FLAGS: rdVal[7:0] = status_q;
			`OFS_RX_MAX_LEN: rdVal[11:0] = rxMaxLen_q;
			`OFS_TIMER_EN: rdVal[2:0] = timerEn_q;
			default: rdVal = '0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			apbRsp_q <= '0;
			dmaReq_q <= '0;
		end else begin
			apbRsp_q.pready <= apbReq.psel && apbReq.penable && !apbRsp_q.pready;
			if (apbReq.psel && apbReq.penable && !apbRsp_q.pready) begin
				apbRsp_q.prdata <= apbReq.pwrite ? 32'h0000_0000 : rdVal;
				apbRsp_q.pslverr <= rdVal == '0 && apbReq.paddr != `OFS_DATA_PORT && apbReq.paddr[1:0] != 2'b00;
			end
			dmaReq_q.txReq <= txEn_q && txCount_q < DEPTH - (PW + 1)'(txPush); // [RULE_04]
			dmaReq_q.rxReq <= rxCount_q > (PW + 1)'(rxPop); // [RULE_04]
		end
	end

endmodule

// [include/infrared_sir_framer_defines.svh]
// Purpose: Offsets, reset values, field positions and timing for the infrared framer
// Assumes: 100 MHz system clock
// Notes: Byte addresses on a 32-bit APB
`ifndef INFRARED_SIR_FRAMER_DEFINES_SVH
`define INFRARED_SIR_FRAMER_DEFINES_SVH

`define OFS_DATA_PORT 8'h00
`define OFS_FIFO_FLUSH 8'h04
`define OFS_MAX_TURN 8'h08
`define OFS_MIN_TURN 8'h0C
`define OFS_EXTRA_FLAGS 8'h10
`define OFS_RATE_DIV 8'h14
`define OFS_TX_LENGTH 8'h18
`define OFS_RX_FIRST_LEN 8'h1C
`define OFS_ABORT 8'h20
`define OFS_TX_CONTROL 8'h24
`define OFS_RX_CONTROL 8'h28
`define OFS_THRESHOLDS 8'h2C
`define OFS_IRQ_MASK 8'h30
`define OFS_IRQ_PENDING 8'h34
`define OFS_RX_FLAGS 8'h38
`define OFS_RX_MAX_LEN 8'h40
`define OFS_TIMER_EN 8'h48

`define RST_MAX_TURN 14'h3E80
`define RST_MIN_TURN 16'hFDE8
`define RST_EXTRA_FLAGS 7'h0B
`define RST_RATE_DIV 16'h0055
`define RST_TX_LENGTH 12'h040

`define TXC_EN 0
`define TXC_MODE 1
`define TXC_INV 2
`define TXC_ONE 3
`define RXC_EN 0
`define RXC_INV 1
`define RXC_ONE 2
`define FLAG_TYPE_BIT 7

`define BYTE_BOF 8'hC0
`define BYTE_EOF 8'hC1
`define BYTE_ESC 8'h7D
`define BYTE_FILL 8'hFF
`define BYTE_XOR 8'h20
`define PF_BIT 4
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h8408
`define CRC_GOOD 16'hF0B8

`define SUB_LAST 4'hF
`define SUB_MID 4'h8
`define PULSE_SUBS 4'h3
`define LAST_BIT 4'h9
`define PULSE_NS 1610
`define CLK_MHZ 100
`define PULSE_CYCLES ((`PULSE_NS * `CLK_MHZ) / 1000)

`endif

// [include/infrared_sir_framer_pkg.sv]
// Purpose: Types shared by the infrared framer and its bench
// Assumes: APB with 32-bit data
// Notes: Byte addresses in paddr
package infrared_sir_framer_pkg;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_type;

	typedef struct packed {
		logic txReq;
		logic rxReq;
	} dma_type;

	typedef enum logic [2:0] {
		T_IDLE = 3'b000,
		T_XBOF = 3'b001,
		T_DATA = 3'b010,
		T_ESC = 3'b011,
		T_FCS = 3'b100,
		T_EOF = 3'b101,
		T_ABORT = 3'b110,
		T_DONE = 3'b111
	} tx_state_type;

	typedef enum logic [1:0] {
		R_HUNT = 2'b00,
		R_DATA = 2'b01,
		R_ESC = 2'b10
	} rx_state_type;

endpackage

// [testbench/infrared_sir_framer_sva.sv]
// Purpose: Port assertions for the framer
// Assumes: Invert, mode and divisor stay put within a frame
// Notes: Shadows a few registers from APB writes
`include "infrared_sir_framer_defines.svh"
module infrared_sir_framer_sva (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire infrared_sir_framer_pkg::apb_req_type apbReq,
	input wire infrared_sir_framer_pkg::apb_rsp_type apbRsp_q,
	input wire infrared_sir_framer_pkg::dma_type dmaReq_q,
	input wire logic irq_q,
	input wire logic irTx_q,
	input wire logic irRx
);
	timeunit 1ns;
	timeprecision 1ps;
	import infrared_sir_framer_pkg::*;
	logic [15:0] div_q, mask_q;
	logic [3:0] txCtl_q;
	logic inv_q, wr;
	logic [17:0] run_q, len;
	assign wr = apbRsp_q.pready && apbReq.pwrite;
	assign len = txCtl_q[`TXC_MODE] ? 18'(`PULSE_CYCLES) : 18'(3 * ((div_q == 16'h0) ? 16'h1 : div_q));
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			div_q <= `RST_RATE_DIV;
			mask_q <= 16'h0;
			txCtl_q <= 4'h0;
		end else if (wr) begin
			case (apbReq.paddr)
				`OFS_RATE_DIV: div_q <= apbReq.pwdata[15:0];
				`OFS_IRQ_MASK: mask_q <= apbReq.pwdata[15:0];
				`OFS_TX_CONTROL: txCtl_q <= apbReq.pwdata[3:0];
				default: ;
			endcase
		end
	end
	// Length of the current light pulse
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			inv_q <= 1'b0;
			run_q <= 18'h0;
		end else begin
			inv_q <= txCtl_q[`TXC_INV];
			run_q <= (irTx_q ^ inv_q) ? run_q + 18'h1 : 18'h0;
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	ready_pulse_a: assert property (apbRsp_q.pready |=> !apbRsp_q.pready)
		else $error("ready held");
	ready_wait_a: assert property (apbReq.psel && apbReq.penable && !apbRsp_q.pready |=> apbRsp_q.pready)
		else $error("ready late");
	slave_error_a: assert property (apbRsp_q.pready |-> apbRsp_q.pslverr == (apbReq.paddr[1:0] != 2'h0))
		else $error("bad error flag");
	pulse_width_a: assert property (run_q != 18'h0 && !(irTx_q ^ inv_q) |-> run_q == len)
		else $error("bad pulse width");
	idle_level_a: assert property (!txCtl_q[`TXC_EN] && !$past(txCtl_q[`TXC_EN], 2) |-> irTx_q == inv_q)
		else $error("bad idle level");
	tx_gate_a: assert property (!txCtl_q[`TXC_EN] && !$past(txCtl_q[`TXC_EN]) |-> !dmaReq_q.txReq)
		else $error("request while off");
	irq_gate_a: assert property (mask_q == 16'h0 && $past(mask_q) == 16'h0 |-> !irq_q)
		else $error("masked irq");
	flush_empty_a: assert property (wr && apbReq.paddr == `OFS_FIFO_FLUSH && apbReq.pwdata[0] |=> ##1 !dmaReq_q.rxReq)
		else $error("flush kept data");
	frame_c: cover property ($fell(irq_q));
	pulse_c: cover property (run_q == len);
	flush_c: cover property (wr && apbReq.paddr == `OFS_FIFO_FLUSH);
endmodule
bind infrared_sir_framer infrared_sir_framer_sva i_sva (.mclk(mclk), .sys_rst(sys_rst), .apbReq(apbReq),
	.apbRsp_q(apbRsp_q), .dmaReq_q(dmaReq_q), .irq_q(irq_q), .irTx_q(irTx_q), .irRx(irRx));

// [testbench/ir_transceiver_model.sv]
// Purpose: Transceiver stand-in that echoes its own light
// Assumes: Two clocks of optical path delay
// Notes: Dark while echo is off
module ir_transceiver_model (
	input wire logic mclk,
	input wire logic echoOn,
	input wire logic light,
	output logic sensed
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] path_q = 2'h0;
	always_ff @(posedge mclk) begin
		path_q <= {path_q[0], echoOn & light};
	end
	assign sensed = path_q[1];
endmodule

// [testbench/infrared_sir_framer_tb_top.sv]
// Purpose: Self-checking bench for the framer
// Assumes: Echoed light forms a loopback frame
// Notes: Reads queue their expectation for the monitor
module infrared_sir_framer_tb_top import infrared_sir_framer_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, sys_rst = 1'b1, echoOn = 1'b0, irRx, irq, irTx;
	apb_req_type apbReq = '0;
	apb_rsp_type apbRsp;
	dma_type dmaReq;
	logic [63:0] expQ[$];
	logic [31:0] rnd = 32'h71C5;
	logic [23:0] rstTab[14] = '{24'h083E80, 24'h0CFDE8, 24'h10000B, 24'h140055, 24'h180040, 24'h1C0000, 24'h200000,
		24'h240000, 24'h280000, 24'h2C0000, 24'h300000, 24'h340000, 24'h380000, 24'h3C0000};
	int err_count = 0, cmp_count = 0, cyc = 0;
	infrared_sir_framer #(.ThreshTicks(16'h0010), .QueueIdleTicks(16'h0010)) i_dut (.mclk(mclk), .sys_rst(sys_rst),
		.apbReq(apbReq), .apbRsp_q(apbRsp), .dmaReq_q(dmaReq), .irq_q(irq), .irTx_q(irTx), .irRx(irRx));
	ir_transceiver_model i_xcvr (.mclk(mclk), .echoOn(echoOn), .light(irTx), .sensed(irRx));
	initial begin
		forever #5 mclk = ~mclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		@(posedge mclk);
		apbReq <= '{1'b1, 1'b0, w, a, d};
		if (!w) expQ.push_back({d, m});
		@(posedge mclk);
		apbReq.penable <= 1'b1;
		do @(posedge mclk); while (apbRsp.pready !== 1'b1);
		apbReq <= '0;
	endtask
	// Read monitor and cycle limit
	always @(posedge mclk) begin
		logic [63:0] e;
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			report_and_stop();
		end
		if (apbRsp.pready === 1'b1 && apbReq.pwrite === 1'b0) begin
			e = expQ.pop_front();
			chk(apbRsp.prdata & e[31:0], e[63:32] & e[31:0]);
		end
	end
	initial begin
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		foreach (rstTab[i]) apb(1'b0, rstTab[i][23:16], 32'(rstTab[i][15:0]), 32'hFFFF);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			apb(1'b1, 8'h2C, rnd, 32'h0);
			apb(1'b0, 8'h2C, rnd, 32'hF);
			apb(1'b1, 8'h1C, rnd, 32'h0);
			apb(1'b0, 8'h1C, 32'h0, 32'hFFF);
		end
		apb(1'b1, 8'h2E, rnd, 32'h0);
		$display("registers done");
		apb(1'b1, 8'h24, 32'h4, 32'h0);
		repeat (3) @(posedge mclk);
		chk(32'(irTx), 32'h1);
		apb(1'b1, 8'h24, 32'h0, 32'h0);
		repeat (3) @(posedge mclk);
		chk(32'(irTx), 32'h0);
		$display("polarity done");
		echoOn <= 1'b1;
		apb(1'b1, 8'h14, 32'h2, 32'h0);
		apb(1'b1, 8'h10, 32'h1, 32'h0);
		apb(1'b1, 8'h18, 32'h2, 32'h0);
		apb(1'b1, 8'h30, 32'h10, 32'h0);
		apb(1'b1, 8'h28, 32'h1, 32'h0);
		apb(1'b1, 8'h00, 32'h7D, 32'h0);
		apb(1'b1, 8'h00, 32'hC0, 32'h0);
		apb(1'b1, 8'h24, 32'h9, 32'h0);
		for (int i = 0; i < 20000 && (irq !== 1'b1 || dmaReq.txReq !== 1'b0); i++) @(posedge mclk);
		chk(32'(irq), 32'h1);
		chk(32'(dmaReq.rxReq), 32'h1);
		apb(1'b0, 8'h34, 32'h18, 32'h18);
		apb(1'b0, 8'h00, 32'h7D, 32'hFF);
		apb(1'b0, 8'h00, 32'hC0, 32'hFF);
		apb(1'b0, 8'h38, 32'h0, 32'h30);
		apb(1'b0, 8'h24, 32'h0, 32'h1);
		apb(1'b0, 8'h34, 32'h0, 32'h18);
		chk(32'(irq), 32'h0);
		rnd = lfsr(rnd);
		apb(1'b1, 8'h18, 32'h1, 32'h0);
		apb(1'b1, 8'h00, rnd, 32'h0);
		apb(1'b1, 8'h24, 32'h9, 32'h0);
		for (int i = 0; i < 20000 && dmaReq.rxReq !== 1'b1; i++) @(posedge mclk);
		chk(32'(dmaReq.rxReq), 32'h1);
		apb(1'b1, 8'h04, 32'h1, 32'h0);
		repeat (3) @(posedge mclk);
		chk(32'(dmaReq.rxReq), 32'h0);
		$display("loopback done");
		report_and_stop();
	end
endmodule
